// ---- src/arsc_pkg.sv ----
/*
 * Package for the ADC reference select control block.
 * Holds the register addresses, field positions, reset values and selector encodings.
 * Assumes an 8-bit special-function-register access port with an 8-bit address.
 */
package arsc_pkg;

	localparam logic [7:0] ARSC_ADDR_TEMP_OFFSET_LOW  = 8'h85;
	localparam logic [7:0] ARSC_ADDR_TEMP_OFFSET_HIGH = 8'h86;
	localparam logic [7:0] ARSC_ADDR_REFERENCE_CTRL   = 8'hD1;

	localparam int ARSC_POS_PREC_REF_OE   = 0;
	localparam int ARSC_POS_TEMP_SENSOR_EN = 2;
	localparam int ARSC_POS_REF_SEL_LO    = 3;
	localparam int ARSC_POS_REF_SEL_HI    = 4;
	localparam int ARSC_POS_GND_SEL       = 5;
	localparam int ARSC_POS_OFFSET_LOW_LO = 6;

	localparam logic [7:0] ARSC_REFCTL_WRITE_MASK = 8'h3D;
	localparam logic [7:0] ARSC_REFCTL_RESET      = 8'h18;
	localparam logic [7:0] ARSC_READ_RESET        = 8'h00;

	// Default factory offset; the real value is loaded from trim storage.
	localparam logic [9:0] ARSC_OFFSET_DEFAULT = 10'h200;

	typedef enum logic [1:0] {
		ARSC_REF_EXT_PIN   = 2'b00,
		ARSC_REF_MAIN_SUPP = 2'b01,
		ARSC_REF_DIG_SUPP  = 2'b10,
		ARSC_REF_HS_INT    = 2'b11
	} arsc_ref_sel_t;

	typedef enum logic {
		ARSC_GND_CHIP   = 1'b0,
		ARSC_GND_ANALOG = 1'b1
	} arsc_gnd_sel_t;

endpackage

// ---- src/arsc_offset_store.sv ----
/*
 * Holds the 10-bit factory temperature offset and presents it as two register bytes.
 * Assumes the trim value and its load strobe come from logic on the same clock.
 */
`timescale 1ns/1ps
module arsc_offset_store
	import arsc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic       trim_load,
	input  wire logic [9:0] trim_value,
	output logic      [7:0] offset_high_byte,
	output logic      [7:0] offset_low_byte
);

	// high byte bits.
	// The bytes load straight from the trim value, so a read on the next edge sees it.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			offset_high_byte <= ARSC_OFFSET_DEFAULT[9:2];
			offset_low_byte  <= {ARSC_OFFSET_DEFAULT[1:0], 6'h00};
		end else if (clk_en && trim_load) begin
			offset_high_byte <= trim_value[9:2];
			offset_low_byte  <= {trim_value[1:0], 6'h00};
		end
	end

endmodule

// ---- src/arsc_top.sv ----
/*
 * ADC reference select control: the reference control register, the offset registers,
 * and the selector outputs to the analog reference and ground multiplexers.
 * Assumes a single-cycle register port on clk, and ADC status inputs from logic on clk.
 */
// Operation
// - Bits 4:3 choose ADC voltage reference.
// - Select 11 powers high-speed reference on demand.
// - Bit 0 enables precision reference onto pin.
// - Bit 5 picks chip or analog ground.
// - Temperature sensor sampling forces chip ground.
// - High-speed reference conversion forces chip ground.
// - Bit 2 powers sensor, else high impedance.
// - Control bits 7:6 and 1 read zero.
// - Offset low byte holds two LSBs high.
// - Offset high byte holds bits 9:2.
`timescale 1ns/1ps
module arsc_top
	import arsc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       trim_load,
	input  wire logic [9:0] trim_value,
	input  wire logic       adc_tracking,
	input  wire logic       adc_converting,
	input  wire logic       adc_needs_ref,
	input  wire logic       temp_channel_selected,
	output logic      [1:0] reference_select,
	output logic            analog_ground_select,
	output logic            precision_ref_output_enable,
	output logic            temp_sensor_enable,
	output logic            temp_sensor_hiz,
	output logic            hs_ref_power
);

	logic [7:0] reference_control;
	logic [7:0] offset_high_byte;
	logic [7:0] offset_low_byte;

	wire        hit_low;
	wire        hit_high;
	wire        hit_refctl;
	wire        take_write;
	wire        take_read;
	wire        wr_refctl;
	wire [7:0]  next_reference_control;
	wire [7:0]  read_mux;
	wire [1:0]  ref_field;
	wire        hs_selected;
	wire        gnd_bit;
	wire        prec_oe_bit;
	wire        sensor_bit;
	wire        sample_temp;
	wire        hs_convert;
	wire        next_ground;
	wire        next_hs_power;

	// Matches a register port address against one register's offset.
	function automatic logic addr_hit(
		input logic [7:0] addr,
		input logic [7:0] target
	);
		addr_hit = (addr == target);
	endfunction

	// Keeps only the writable control bits, so an unused bit never holds a one.
	function automatic logic [7:0] control_bits(
		input logic [7:0] value
	);
		control_bits = value & ARSC_REFCTL_WRITE_MASK;
	endfunction

	// Returns the reference-select field of a control byte.
	function automatic logic [1:0] ref_field_of(
		input logic [7:0] value
	);
		ref_field_of = value[ARSC_POS_REF_SEL_HI:ARSC_POS_REF_SEL_LO];
	endfunction

	// Picks the ADC ground reference; either internal override beats the bit.
	function automatic logic ground_choice(
		input logic sampling_sensor,
		input logic hs_conversion,
		input logic ground_bit
	);
		if (sampling_sensor || hs_conversion) begin
			ground_choice = ARSC_GND_CHIP;
		end else begin
			ground_choice = ground_bit;
		end
	endfunction

	function automatic logic [7:0] read_select(
		input logic       sel_refctl,
		input logic       sel_high,
		input logic       sel_low,
		input logic [7:0] control,
		input logic [7:0] high_byte,
		input logic [7:0] low_byte
	);
		if (sel_refctl) begin
			read_select = control_bits(control);
		end else if (sel_high) begin
			read_select = high_byte;
		end else if (sel_low) begin
			read_select = low_byte;
		end else begin
			read_select = ARSC_READ_RESET;
		end
	endfunction

	assign hit_low    = addr_hit(reg_addr, ARSC_ADDR_TEMP_OFFSET_LOW);
	assign hit_high   = addr_hit(reg_addr, ARSC_ADDR_TEMP_OFFSET_HIGH);
	assign hit_refctl = addr_hit(reg_addr, ARSC_ADDR_REFERENCE_CTRL);
	assign take_write = clk_en && reg_write;
	assign take_read  = clk_en && reg_read;

	// The offset bytes are read-only, so only the control register decodes a write.
	assign wr_refctl  = take_write && hit_refctl;

	assign next_reference_control = control_bits(reg_wdata);

	assign read_mux = read_select(
		hit_refctl,
		hit_high,
		hit_low,
		reference_control,
		offset_high_byte,
		offset_low_byte
	);

	assign ref_field   = ref_field_of(reference_control);
	assign hs_selected = (ref_field == ARSC_REF_HS_INT);
	assign gnd_bit     = reference_control[ARSC_POS_GND_SEL];
	assign prec_oe_bit = reference_control[ARSC_POS_PREC_REF_OE];
	assign sensor_bit  = reference_control[ARSC_POS_TEMP_SENSOR_EN];

	assign sample_temp = adc_tracking && temp_channel_selected;

	assign hs_convert  = hs_selected && adc_converting;

	// ground select bit.
	// The ground output is registered, so it follows the ADC phase one clock late.
	// The ADC must open its tracking and conversion phases with that clock in hand.
	assign next_ground = ground_choice(sample_temp, hs_convert, gnd_bit);

	// on-demand high-speed power.
	// Power follows the ADC request while select 11 is set, so software has no other enable for it.
	assign next_hs_power = hs_selected && adc_needs_ref;

	arsc_offset_store u_offset (
		.clk              (clk),
		.reset_n          (reset_n),
		.clk_en           (clk_en),
		.trim_load        (trim_load),
		.trim_value       (trim_value),
		.offset_high_byte (offset_high_byte),
		.offset_low_byte  (offset_low_byte)
	);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reference_control <= ARSC_REFCTL_RESET;
		end else if (wr_refctl) begin
			reference_control <= next_reference_control;
		end
	end

	// Read data stands until the next read, so a slow reader never loses it.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= ARSC_READ_RESET;
		end else if (take_read) begin
			reg_rdata <= read_mux;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reference_select <= ARSC_REFCTL_RESET[ARSC_POS_REF_SEL_HI:ARSC_POS_REF_SEL_LO];
		end else if (clk_en) begin
			reference_select <= ref_field;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			analog_ground_select <= ARSC_REFCTL_RESET[ARSC_POS_GND_SEL];
		end else if (clk_en) begin
			analog_ground_select <= next_ground;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			precision_ref_output_enable <= ARSC_REFCTL_RESET[ARSC_POS_PREC_REF_OE];
		end else if (clk_en) begin
			precision_ref_output_enable <= prec_oe_bit;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			temp_sensor_enable <= ARSC_REFCTL_RESET[ARSC_POS_TEMP_SENSOR_EN];
		end else if (clk_en) begin
			temp_sensor_enable <= sensor_bit;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			temp_sensor_hiz <= !ARSC_REFCTL_RESET[ARSC_POS_TEMP_SENSOR_EN];
		end else if (clk_en) begin
			temp_sensor_hiz <= !sensor_bit;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hs_ref_power <= 1'b0;
		end else if (clk_en) begin
			hs_ref_power <= next_hs_power;
		end
	end

endmodule

// ---- sim/arsc_assertions.sv ----
/* Port checker for arsc_top; assumes it is bound onto arsc_top, clk_en mostly high. */
`timescale 1ns/1ps
module arsc_chk(
	input wire logic clk, reset_n, clk_en, reg_write, reg_read, adc_tracking, adc_converting,
	input wire logic adc_needs_ref, temp_channel_selected, analog_ground_select, hs_ref_power,
	input wire logic precision_ref_output_enable, temp_sensor_enable, temp_sensor_hiz,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [1:0] reference_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire w = clk_en && reg_write && reg_addr == 8'hD1;
	wire r = clk_en && reg_read;
	wire hs = clk_en && reference_select == 2'b11;
	a_sel_write:
		assert property (w ##1 clk_en |=> reference_select == $past(reg_wdata[4:3], 2)) else $error("sel");
	a_oe_write:
		assert property (w ##1 clk_en |=> precision_ref_output_enable == $past(reg_wdata[0], 2))
		else $error("oe");
	a_gnd_write:
		assert property (w ##1 clk_en && !adc_converting && !adc_tracking
			|=> analog_ground_select == $past(reg_wdata[5], 2)) else $error("gnd");
	a_gnd_temp:
		assert property (clk_en && adc_tracking && temp_channel_selected |=> !analog_ground_select)
		else $error("gnd temp");
	a_gnd_hsref:
		assert property (hs && adc_converting ##1 hs |-> !analog_ground_select) else $error("gnd hs");
	a_hs_power:
		assert property (hs && adc_needs_ref ##1 hs |-> hs_ref_power) else $error("hs power");
	a_hiz_inverse:
		assert property (temp_sensor_hiz != temp_sensor_enable) else $error("hiz");
	a_ctrl_zeros:
		assert property (r && reg_addr == 8'hD1 |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[1])
		else $error("ctrl zeros");
	a_low_zeros:
		assert property (r && reg_addr == 8'h85 |=> reg_rdata[5:0] == 6'h00) else $error("low zeros");
	c_write: cover property (w);
	c_hs: cover property (hs_ref_power);
	c_low: cover property (r && reg_addr == 8'h85);
endmodule
bind arsc_top arsc_chk u_arsc_chk (.*);

// ---- sim/arsc_adc_model.sv ----
/* ADC status source; assumes the bench sets cmd at the falling clock edge. */
`timescale 1ns/1ps
module arsc_adc_model(
	input  wire logic       clk,
	input  wire logic [3:0] cmd,
	output logic            adc_tracking, adc_converting, adc_needs_ref, temp_channel_selected
);
	always_ff @(posedge clk)
		{adc_tracking, adc_converting, adc_needs_ref, temp_channel_selected} <= cmd;
endmodule

// ---- sim/adc_reference_select_control_test.sv ----
/* Bench for arsc_top; assumes the checker is bound in and the ADC model drives status. */
`timescale 1ns/1ps
module adc_reference_select_control_test;
	logic clk = 0, reset_n = 0, clk_en = 1, reg_write = 0, reg_read = 0, trim_load = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [9:0] trim_value = 0;
	logic [3:0] cmd = 0;
	logic adc_tracking, adc_converting, adc_needs_ref, temp_channel_selected, hs_ref_power;
	logic analog_ground_select, precision_ref_output_enable, temp_sensor_enable, temp_sensor_hiz;
	logic [1:0] reference_select;
	int bad_count = 0, checks_done = 0;
	// reference set-ups; the reference is enabled before any clock change.
	logic [15:0] rows [6] = '{16'hFF3D, 16'h0000, 16'h0101, 16'h0909, 16'h1210, 16'hE725};
	always #2 clk = ~clk;
	arsc_top u_arsc_top(.*);
	arsc_adc_model u_arsc_adc_model(.*);
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, s);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1;
		@(negedge clk) reg_write = 0;
	endtask
	task rd(input logic [7:0] a, e);
		@(negedge clk);
		reg_addr = a;
		reg_read = 1;
		@(negedge clk) reg_read = 0;
		chk("rdata", e, reg_rdata);
	endtask
	initial begin
		repeat (3) @(negedge clk);
		reset_n = 1;
		chk("reset sel", 3, reference_select);
		rd(8'hD1, 8'h18);
		rd(8'h86, 8'h80);
		foreach (rows[i]) begin
			wr(8'hD1, rows[i][15:8]);
			@(negedge clk);
			chk("sel", rows[i][12:11], reference_select);
			chk("oe", rows[i][8], precision_ref_output_enable);
			chk("gnd", rows[i][13], analog_ground_select);
			chk("hiz", !rows[i][10], temp_sensor_hiz);
			chk("sen", rows[i][10], temp_sensor_enable);
			rd(8'hD1, rows[i][7:0]);
		end
		$display("table done");
		trim_value = 10'h2B7;
		trim_load = 1;
		@(negedge clk) trim_load = 0;
		wr(8'h85, 8'hFF);
		rd(8'h85, 8'hC0);
		rd(8'h86, 8'hAD);
		rd(8'h40, 8'h00);
		$display("offset done");
		wr(8'hD1, 8'h20);
		cmd = 4'b1011;
		repeat (3) @(negedge clk);
		chk("gnd temp", 0, analog_ground_select);
		chk("hs off", 0, hs_ref_power);
		wr(8'hD1, 8'h38);
		cmd = 4'b0110;
		repeat (3) @(negedge clk);
		chk("gnd hs", 0, analog_ground_select);
		chk("hs on", 1, hs_ref_power);
		$display("override done");
		clk_en = 0;
		wr(8'hD1, 8'h00);
		@(negedge clk);
		chk("frozen sel", 3, reference_select);
		chk("frozen hs", 1, hs_ref_power);
		clk_en = 1;
		rd(8'hD1, 8'h38);
		reset_n = 0;
		@(negedge clk) reset_n = 1;
		chk("reset hiz", 1, temp_sensor_hiz);
		rd(8'hD1, 8'h18);
		rd(8'h86, 8'h80);
		$display("freeze and reset done");
		report_and_stop;
	end
	initial begin
		#2000;
		bad_count++;
		report_and_stop;
	end
endmodule
